//--- asc_consts.svh
// Constants for the serial configuration port of the dual-channel transcoder
`ifndef ASC_CONSTS_SVH
`define ASC_CONSTS_SVH

// ----------------------------------------------------------------------
// Channel control byte fields
// ----------------------------------------------------------------------
`define ASC_CR_IDLE        5
`define ASC_CR_RESTART     4
`define ASC_CR_PASS        3
`define ASC_CR_LAW         2
`define ASC_CR_DIR         0
`define ASC_CTRL_RST       8'h20

// ----------------------------------------------------------------------
// Address/command and timeslot byte fields
// ----------------------------------------------------------------------
`define ASC_ACB_SIDE       6
`define ASC_ACB_ADDR_MSB   5
`define ASC_SLOT_MSB       5

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define ASC_CLK_MHZ        125
`define ASC_WAKE_MS        200
`define ASC_RESTART_CYCLES 16
`define ASC_LAST_BIT       3'h7
`define ASC_BITPOS_MAX     10'h3ff

`endif

//--- asc_host_model.sv
// Host microcontroller model driving the three-wire serial port
`timescale 1ns/1ps

module asc_host_model (
   // Serial port
   output logic sclk_o,
   output logic sdi_o,
   output logic cs_n_o
);
   // Half period of the 160 ns link clock
   localparam time HALF = 80ns;

   initial begin
      sclk_o = 1'b0;
      sdi_o  = 1'b0;
      cs_n_o = 1'b0;
      // One chip select rise clears the serial bit counter
      #(10ns) cs_n_o = 1'b1;
   end

   // ------------------------------------------------------------
   // One write frame, clock still outside the frame
   // ------------------------------------------------------------
   task automatic send(input logic [7:0] b [5], input int n);
      #(1.7ns);
      cs_n_o = 1'b0;
      for (int k = 0; k < n; k++) begin
         for (int i = 0; i < 8; i++) begin
            sdi_o = b[k][i];
            #(HALF) sclk_o = 1'b1;
            #(HALF) sclk_o = 1'b0;
         end
      end
      #(HALF) cs_n_o = 1'b1;
      sdi_o = ~sdi_o;
      #(HALF);
   endtask : send

   // Static levels used as straps in hardware mode
   task automatic strap(input logic cs_n, input logic serial_data_input);
      cs_n_o = cs_n;
      sdi_o  = serial_data_input;
   endtask : strap
endmodule : asc_host_model

//--- asc_pkg.sv
// Types for the serial configuration port of the dual-channel transcoder
package asc_pkg;

   // ----------------------------------------------------------------------
   // Per-side configuration
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic       idle;
      logic       restart;
      logic       passthru;
      logic       mulaw;
      logic       compress;
      logic [5:0] in_slot;
      logic [5:0] out_slot;
   } asc_side_cfg_t;

   // ----------------------------------------------------------------------
   // Position of the next byte within a write
   // ----------------------------------------------------------------------
   typedef enum logic [2:0] {
      ASC_ST_CMD,
      ASC_ST_CTRL,
      ASC_ST_ISLOT,
      ASC_ST_OSLOT,
      ASC_ST_DONE
   } asc_stage_t;

endpackage : asc_pkg

//--- asc_serial_config_port.sv
// Serial configuration port with per-side control, timeslot counters and standby
`timescale 1ns/1ps
`include "asc_consts.svh"

module asc_serial_config_port
   import asc_pkg::*;
#(
   parameter bit NEW_REC     = 1'b1,
   parameter int WAKE_CYCLES = `ASC_WAKE_MS * `ASC_CLK_MHZ * 1000
) (
   // Clock and reset
   input  wire logic          CLK_I,
   input  wire logic          RST_N_I,
   // Serial port
   input  wire logic          SERIAL_CLK_I,
   input  wire logic          SERIAL_DATA_INPUT_I,
   input  wire logic          CHIP_SELECT_N_I,
   // Straps
   input  wire logic [5:0]    DEVICE_ADDRESS_PINS_I,
   input  wire logic          PORT_MODE_SELECT_PIN_I,
   // PCM framing
   input  wire logic          PCM_CLK_X_I,
   input  wire logic          PCM_CLK_Y_I,
   input  wire logic          FRAME_PULSE_X_I,
   input  wire logic          FRAME_PULSE_Y_I,
   // Configuration to the engine
   output asc_side_cfg_t      CFG_X_O,
   output asc_side_cfg_t      CFG_Y_O,
   output logic               STANDBY_O,
   output logic               UPDATE_BUSY_O,
   // Timeslot windows, index 1 is X, index 0 is Y
   output logic [1:0]         IN_WIN_O,
   output logic [1:0]         OUT_EN_O
);

   localparam int WAKE_W = $clog2(WAKE_CYCLES + 1);

   // ----------------------------------------------------------------------
   // Functions
   // ----------------------------------------------------------------------
   function automatic asc_side_cfg_t apply_ctrl(input asc_side_cfg_t c, input logic [7:0] b);
      asc_side_cfg_t r;
      r          = c;
      r.idle     = b[`ASC_CR_IDLE];
      r.restart  = b[`ASC_CR_RESTART];
      r.passthru = b[`ASC_CR_PASS];
      r.mulaw    = b[`ASC_CR_LAW];
      r.compress = b[`ASC_CR_DIR];
      return r;
   endfunction : apply_ctrl

   function automatic logic slot_hit(input logic [9:0] pos, input logic wide, input logic [5:0] slot);
      logic hit;
      hit = wide ? (pos[9] == 1'b0 && pos[8:3] == slot) : (pos[9:8] == 2'h0 && pos[7:2] == slot);
      return hit;
   endfunction : slot_hit

   function automatic logic [2:0] to_gray(input logic [2:0] b);
      return b ^ {1'b0, b[2:1]};
   endfunction : to_gray

   // ----------------------------------------------------------------------
   // Serial clock domain
   // ----------------------------------------------------------------------
   logic [2:0]    bit_cnt;
   logic [2:0]    bit_gray;
   logic [7:0]    shift;
   logic [7:0]    byte_hold;
   wire  [7:0]    next_byte = {SERIAL_DATA_INPUT_I, shift[7:1]};
   wire  [2:0]    next_cnt  = bit_cnt + 3'h1;

   // Chip select high ends the frame, with no serial clock edge needed
   always_ff @(posedge SERIAL_CLK_I or posedge CHIP_SELECT_N_I) begin
      if (CHIP_SELECT_N_I) begin
         bit_cnt  <= 3'h0;
         bit_gray <= 3'h0;
      end else begin
         bit_cnt  <= next_cnt;
         bit_gray <= to_gray(next_cnt);
      end
   end

   always_ff @(posedge SERIAL_CLK_I) begin
      shift <= next_byte;
      if (!CHIP_SELECT_N_I && bit_cnt == `ASC_LAST_BIT) begin
         byte_hold <= next_byte;
      end
   end

   property byte_capture_p;
      @(posedge SERIAL_CLK_I) disable iff (CHIP_SELECT_N_I)
      bit_cnt == `ASC_LAST_BIT |=> bit_gray == 3'h0 && byte_hold == $past(next_byte);
   endproperty
   byte_capture_a: assert property (byte_capture_p) else $error("serial byte not captured");

   // ----------------------------------------------------------------------
   // Synchronisers into the master clock domain
   // ----------------------------------------------------------------------
   logic [2:0]    gray_s1, gray_s2, gray_s3;
   logic [5:0]    addr_s1, addr_s2;
   logic          sps_s1, sps_s2;
   logic          cs_s1, cs_s2;
   logic          sdi_s1, sdi_s2;
   logic [1:0]    pclk_s1, pclk_s2, pclk_s3;
   logic [1:0]    fs_s1, fs_s2, fs_s3;

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         {gray_s1, gray_s2, gray_s3} <= 9'h000;
         {cs_s1, cs_s2}              <= 2'h3;
      end else begin
         gray_s1 <= bit_gray;
         gray_s2 <= gray_s1;
         gray_s3 <= gray_s2;
         cs_s1   <= CHIP_SELECT_N_I;
         cs_s2   <= cs_s1;
      end
   end

   always_ff @(posedge CLK_I) begin
      addr_s1 <= DEVICE_ADDRESS_PINS_I;
      addr_s2 <= addr_s1;
      sps_s1  <= PORT_MODE_SELECT_PIN_I;
      sps_s2  <= sps_s1;
      sdi_s1  <= SERIAL_DATA_INPUT_I;
      sdi_s2  <= sdi_s1;
      pclk_s1 <= {PCM_CLK_X_I, PCM_CLK_Y_I};
      pclk_s2 <= pclk_s1;
      pclk_s3 <= pclk_s2;
      fs_s1   <= {FRAME_PULSE_X_I, FRAME_PULSE_Y_I};
      fs_s2   <= fs_s1;
      fs_s3   <= fs_s2;
   end

   // ----------------------------------------------------------------------
   // Write sequencing
   // ----------------------------------------------------------------------
   asc_stage_t    stage;
   asc_stage_t    next_stage;
   logic          match;
   logic          side;
   wire           sw_mode  = sps_s2;
   wire           byte_evt = gray_s3 == to_gray(`ASC_LAST_BIT) && gray_s2 == 3'h0;
   wire           addr_eq  = byte_hold[`ASC_ACB_ADDR_MSB:0] == addr_s2;
   wire           wr_ok    = byte_evt && match && sw_mode;
   wire           wr_ctrl  = wr_ok && stage == ASC_ST_CTRL;
   wire           wr_islot = wr_ok && stage == ASC_ST_ISLOT;
   wire           wr_oslot = wr_ok && stage == ASC_ST_OSLOT;

   always_comb begin
      case (stage)
         ASC_ST_CMD:   next_stage = ASC_ST_CTRL;
         ASC_ST_CTRL:  next_stage = ASC_ST_ISLOT;
         ASC_ST_ISLOT: next_stage = ASC_ST_OSLOT;
         ASC_ST_OSLOT: next_stage = ASC_ST_DONE;
         default:      next_stage = ASC_ST_DONE;
      endcase
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         stage <= ASC_ST_CMD;
         match <= 1'b0;
         side  <= 1'b0;
      end else if (byte_evt) begin
         stage <= next_stage;
         if (stage == ASC_ST_CMD) begin
            match <= addr_eq && sw_mode;
            side  <= byte_hold[`ASC_ACB_SIDE];
         end
      end else if (cs_s2) begin
         stage <= ASC_ST_CMD;
         match <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Per-side registers, index 1 is X and 0 is Y
   // ----------------------------------------------------------------------
   asc_side_cfg_t cfg [2];
   asc_side_cfg_t hw_cfg [2];
   logic [4:0]    rcnt [2];
   logic [1:0]    rs_done;

   assign hw_cfg[1] = apply_ctrl('0, {2'h0, cs_s2, 2'h0, addr_s2[2], 1'b0, addr_s2[0]});
   assign hw_cfg[0] = apply_ctrl('0, {2'h0, sdi_s2, 2'h0, addr_s2[5], 1'b0, addr_s2[3]});
   assign rs_done[1] = cfg[1].restart && rcnt[1] == 5'(`ASC_RESTART_CYCLES - 1);
   assign rs_done[0] = cfg[0].restart && rcnt[0] == 5'(`ASC_RESTART_CYCLES - 1);

   always_ff @(posedge CLK_I) begin
      for (int s = 0; s < 2; s++) begin
         if (!RST_N_I) begin
            cfg[s] <= apply_ctrl('0, `ASC_CTRL_RST);
         end else if (!sw_mode) begin
            cfg[s] <= hw_cfg[s];
         end else if (wr_ctrl && side == s[0]) begin
            cfg[s] <= apply_ctrl(cfg[s], byte_hold);
         end else begin
            if (rs_done[s]) begin
               cfg[s].restart <= 1'b0;
            end
            if (wr_islot && side == s[0]) begin
               cfg[s].in_slot <= byte_hold[`ASC_SLOT_MSB:0];
            end
            if (wr_oslot && side == s[0]) begin
               cfg[s].out_slot <= byte_hold[`ASC_SLOT_MSB:0];
            end
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      for (int s = 0; s < 2; s++) begin
         if (!RST_N_I || !cfg[s].restart || (wr_ctrl && side == s[0])) begin
            rcnt[s] <= 5'h00;
         end else begin
            rcnt[s] <= rcnt[s] + 5'h01;
         end
      end
   end

   assign CFG_X_O = cfg[1];
   assign CFG_Y_O = cfg[0];

   sequence restart_due_s;
      rs_done[1] && !(wr_ctrl && side);
   endsequence

   property restart_clear_p;
      @(posedge CLK_I) disable iff (!RST_N_I)
      restart_due_s |=> !cfg[1].restart;
   endproperty
   restart_self_clear_a: assert property (restart_clear_p) else $error("restart bit not cleared");

   restart_bound_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      cfg[1].restart |-> rcnt[1] < 5'(`ASC_RESTART_CYCLES)) else $error("restart held too long");

   side_x_write_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      wr_ctrl && side |=> cfg[1].idle == $past(byte_hold[`ASC_CR_IDLE])
                      && cfg[1].compress == $past(byte_hold[`ASC_CR_DIR])) else $error("X write lost");

   side_y_write_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      wr_islot && !side |=> cfg[0].in_slot == $past(byte_hold[5:0]) && $stable(cfg[1].in_slot))
      else $error("Y slot write wrong");

   mismatch_ignore_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      byte_evt && stage != ASC_ST_CMD && !match && sw_mode |=> $stable(cfg[1]) || $past(rs_done[1]))
      else $error("write taken after mismatch");

   reset_idle_a: assert property (@(posedge CLK_I)
      !RST_N_I |=> cfg[1].idle && cfg[0].idle && !cfg[1].passthru && !cfg[0].compress)
      else $error("reset state wrong");

   hw_slot_zero_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      !sw_mode |=> cfg[1].in_slot == 6'h00 && cfg[0].out_slot == 6'h00) else $error("hardware slots not zero");

   hw_strap_map_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      !sw_mode |=> cfg[1].mulaw == $past(addr_s2[2]) && cfg[0].mulaw == $past(addr_s2[5])
                   && cfg[1].idle == $past(cs_s2)) else $error("hardware strap map wrong");

   // ----------------------------------------------------------------------
   // Standby and wake
   // ----------------------------------------------------------------------
   logic              both_idle_q;
   logic [WAKE_W-1:0] wake_cnt;
   wire               both_idle = cfg[1].idle && cfg[0].idle;
   wire               wake_last = wake_cnt == WAKE_W'(WAKE_CYCLES - 1);

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         both_idle_q <= 1'b1;
         STANDBY_O   <= NEW_REC;
         wake_cnt    <= '0;
      end else begin
         both_idle_q <= both_idle;
         if (both_idle) begin
            wake_cnt <= '0;
            if (!both_idle_q) begin
               STANDBY_O <= 1'b1;
            end
         end else if (STANDBY_O && NEW_REC) begin
            wake_cnt <= wake_cnt + WAKE_W'(1);
            if (wake_last) begin
               STANDBY_O <= 1'b0;
            end
         end
      end
   end

   standby_entry_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      both_idle && !both_idle_q |=> STANDBY_O) else $error("standby not entered");

   wake_time_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      $fell(STANDBY_O) |-> NEW_REC && $past(wake_last) && !$past(both_idle)) else $error("wake timing wrong");

   wake_bound_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      STANDBY_O && !both_idle |-> wake_cnt < WAKE_W'(WAKE_CYCLES)) else $error("wake count overrun");

   // ----------------------------------------------------------------------
   // Timeslot counters
   // ----------------------------------------------------------------------
   logic [9:0]    bit_pos [2];
   logic [1:0]    in_hit, out_hit;
   wire  [1:0]    pclk_rise = pclk_s2 & ~pclk_s3;
   wire  [1:0]    fs_rise   = fs_s2 & ~fs_s3;

   assign in_hit[1]  = slot_hit(bit_pos[1], cfg[1].compress, cfg[1].in_slot);
   assign in_hit[0]  = slot_hit(bit_pos[0], cfg[0].compress, cfg[0].in_slot);
   assign out_hit[1] = slot_hit(bit_pos[1], cfg[1].compress, cfg[1].out_slot);
   assign out_hit[0] = slot_hit(bit_pos[0], cfg[0].compress, cfg[0].out_slot);

   always_ff @(posedge CLK_I) begin
      for (int s = 0; s < 2; s++) begin
         if (!RST_N_I || fs_rise[s]) begin
            bit_pos[s] <= 10'h000;
         end else if (pclk_rise[s] && bit_pos[s] != `ASC_BITPOS_MAX) begin
            bit_pos[s] <= bit_pos[s] + 10'h001;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         IN_WIN_O      <= 2'h0;
         OUT_EN_O      <= 2'h0;
         UPDATE_BUSY_O <= 1'b0;
      end else begin
         UPDATE_BUSY_O <= match && !cs_s2;
         for (int s = 0; s < 2; s++) begin
            IN_WIN_O[s] <= in_hit[s] && !cfg[s].idle && !STANDBY_O;
            OUT_EN_O[s] <= out_hit[s] && !cfg[s].idle && !STANDBY_O && !(match && !cs_s2);
         end
      end
   end

   frame_restart_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      fs_rise[1] |=> bit_pos[1] == 10'h000) else $error("slot count not restarted");

   busy_tristate_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      UPDATE_BUSY_O |-> OUT_EN_O == 2'h0) else $error("output driven during update");

   idle_tristate_a: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      cfg[0].idle ##1 cfg[0].idle |-> !OUT_EN_O[0]) else $error("idle side drives output");

endmodule : asc_serial_config_port

//--- asc_serial_config_port_tb.sv
// Self-checking testbench of the serial configuration port
`timescale 1ns/1ps

module asc_serial_config_port_tb
   import asc_pkg::*;
;
   logic          clk, rst_n, mode, pclk, fp, sclk, serial_data_input, cs_n, stby, busy, stby_old;
   logic [5:0]    addr;
   logic [1:0]    in_win, out_en;
   asc_side_cfg_t cfg_x, cfg_y, ex, ey, rstv;
   logic [33:0]   note_q [$];
   int            err_total, comparisons;

   asc_host_model u_host (.sclk_o(sclk), .sdi_o(serial_data_input), .cs_n_o(cs_n));

   asc_serial_config_port #(.NEW_REC(1'b1), .WAKE_CYCLES(50)) u_dut (
      .CLK_I(clk), .RST_N_I(rst_n), .SERIAL_CLK_I(sclk), .SERIAL_DATA_INPUT_I(serial_data_input),
      .CHIP_SELECT_N_I(cs_n), .DEVICE_ADDRESS_PINS_I(addr), .PORT_MODE_SELECT_PIN_I(mode),
      .PCM_CLK_X_I(pclk), .PCM_CLK_Y_I(pclk), .FRAME_PULSE_X_I(fp), .FRAME_PULSE_Y_I(fp),
      .CFG_X_O(cfg_x), .CFG_Y_O(cfg_y), .STANDBY_O(stby), .UPDATE_BUSY_O(busy),
      .IN_WIN_O(in_win), .OUT_EN_O(out_en));

   asc_serial_config_port #(.NEW_REC(1'b0), .WAKE_CYCLES(50)) u_old (
      .CLK_I(clk), .RST_N_I(rst_n), .SERIAL_CLK_I(sclk), .SERIAL_DATA_INPUT_I(serial_data_input),
      .CHIP_SELECT_N_I(cs_n), .DEVICE_ADDRESS_PINS_I(addr), .PORT_MODE_SELECT_PIN_I(mode),
      .PCM_CLK_X_I(pclk), .PCM_CLK_Y_I(pclk), .FRAME_PULSE_X_I(fp), .FRAME_PULSE_Y_I(fp),
      .CFG_X_O(), .CFG_Y_O(), .STANDBY_O(stby_old), .UPDATE_BUSY_O(), .IN_WIN_O(), .OUT_EN_O());

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic asc_side_cfg_t mk(input logic [7:0] c, input logic [7:0] is, input logic [7:0] os);
      mk = '{idle: c[5], restart: 1'b0, passthru: c[3], mulaw: c[2], compress: c[0],
             in_slot: is[5:0], out_slot: os[5:0]};
   endfunction : mk

   task automatic chk(input string what, input logic [39:0] exp, input logic [39:0] got);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask : chk

   task automatic close_out();
      $display("comparisons %0d, err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : close_out

   // Write frame; a matched frame notes the expected pair of sides
   task automatic wr(input logic side, input logic [7:0] c, input logic [7:0] is, input logic [7:0] os,
                     input int n, input logic hit);
      logic [7:0]    b [5];
      asc_side_cfg_t cur;
      repeat (40) @(negedge clk);
      b[0] = {1'b0, side, hit ? addr : ~addr};
      b[1] = c;
      b[2] = is;
      b[3] = os;
      b[4] = 8'($urandom);
      cur = side ? ex : ey;
      if (n < 4) begin
         is = {2'b00, cur.in_slot};
         os = {2'b00, cur.out_slot};
      end
      if (hit && side) ex = mk(c, is, os);
      if (hit && !side) ey = mk(c, is, os);
      if (hit) note_q.push_back({ex, ey});
      u_host.send(b, n);
   endtask : wr

   // Program side X, then walk 40 bit positions of one frame
   task automatic pcm_run(input logic [7:0] c);
      logic [39:0] in_m, out_m, y_m, unit;
      int          w;
      w = c[0] ? 8 : 4;
      unit = c[5] ? 40'h0 : (40'h1 << w) - 40'h1;
      wr(1'b1, c, 8'h02, 8'h03, 4, 1'b1);
      repeat (60) @(negedge clk);
      fp = 1'b1;
      for (int k = 0; k < 40; k++) begin
         if (k > 0) begin
            pclk = 1'b1;
            repeat (8) @(negedge clk);
            pclk = 1'b0;
            fp = 1'b0;
         end
         repeat (8) @(negedge clk);
         in_m[k] = in_win[1];
         out_m[k] = out_en[1];
         y_m[k] = in_win[0] | out_en[0];
      end
      chk("in window", unit << (2 * w), in_m);
      chk("out window", unit << (3 * w), out_m);
      chk("idle side windows", 40'h0, y_m);
   endtask : pcm_run

   // ------------------------------------------------------------
   // Result watcher
   // ------------------------------------------------------------
   initial begin
      logic was_busy;
      was_busy = 1'b0;
      forever begin
         @(negedge clk);
         if (busy === 1'b1) chk("out during update", 40'h0, 40'(out_en));
         if (was_busy === 1'b1 && busy === 1'b0) begin
            repeat (24) @(negedge clk);
            chk("cfg pair", note_q.size() > 0 ? 40'(note_q.pop_front()) : 'x, 40'({cfg_x, cfg_y}));
         end
         was_busy = busy;
      end
   end

   initial begin
      #400us;
      err_total++;
      close_out();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      logic [7:0] runs [5];
      runs = '{8'h01, 8'h00, 8'h09, 8'h08, 8'h21};
      void'($urandom(32'h4e0ff3a7));
      {rst_n, mode, pclk, fp} = 4'b0100;
      addr = 6'($urandom);
      rstv = mk(8'h20, 8'h00, 8'h00);
      ex = rstv;
      ey = rstv;
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      chk("reset cfg", 40'({ex, ey}), 40'({cfg_x, cfg_y}));
      chk("reset flags", 40'h40, 40'({stby, stby_old, busy, in_win, out_en}));
      for (int i = 0; i < 8; i++) begin
         wr(1'($urandom), 8'($urandom) & 8'h2d, 8'($urandom) & 8'h3f, 8'($urandom) & 8'h3f,
            (i % 3 == 0) ? 2 : 4 + i % 2, i != 3);
      end
      wr(1'b1, 8'h00, 8'h00, 8'h00, 2, 1'b1);
      wr(1'b1, 8'h20, 8'h00, 8'h00, 2, 1'b1);
      wr(1'b0, 8'h20, 8'h00, 8'h00, 2, 1'b1);
      repeat (10) @(negedge clk);
      chk("standby entry", 40'h3, 40'({stby, stby_old}));
      fork
         wr(1'b1, 8'h10, 8'h00, 8'h00, 2, 1'b1);
         begin
            wait (cfg_x.restart === 1'b1);
            repeat (15) @(negedge clk);
            chk("restart set", 40'h1, 40'(cfg_x.restart));
            repeat (2) @(negedge clk);
            chk("restart end", 40'h0, 40'(cfg_x.restart));
         end
      join
      chk("standby hold", 40'h3, 40'({stby, stby_old}));
      repeat (60) @(negedge clk);
      chk("restart clear", 40'h0, 40'(cfg_x.restart));
      chk("standby exit", 40'h1, 40'({stby, stby_old}));
      for (int i = 0; i < 5; i++) pcm_run(runs[i]);
      rst_n = 1'b0;
      mode = 1'b0;
      addr = 6'b101101;
      u_host.strap(1'b0, 1'b1);
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      repeat (8) @(negedge clk);
      chk("hw mode", 40'({mk(8'h05, 8'h00, 8'h00), mk(8'h25, 8'h00, 8'h00)}), 40'({cfg_x, cfg_y}));
      rst_n = 1'b0;
      mode = 1'b1;
      u_host.strap(1'b1, 1'b0);
      repeat (6) @(negedge clk);
      rst_n = 1'b1;
      @(negedge clk);
      ex = rstv;
      ey = rstv;
      chk("reset again", 40'({rstv, rstv, 2'b01}), 40'({cfg_x, cfg_y, stby_old, stby}));
      wr(1'b0, 8'h04, 8'h05, 8'h06, 4, 1'b1);
      repeat (40) @(negedge clk);
      close_out();
   end
endmodule : asc_serial_config_port_tb
